//--- shared/glr_pkg.sv
/*
  Package for the genlock counter reset and offset block: register
  indices, field positions, reset values and state encodings.
  Assumes a 16-bit host register port with word-indexed addresses.
*/
`default_nettype none
package glr_pkg;
  localparam int          GLR_AW                = 5;
  localparam int          GLR_DW                = 16;
  localparam logic [4:0]  GLR_IDX_GENLOCK_CTRL  = 5'h16;
  localparam logic [4:0]  GLR_IDX_LINE_PERIOD   = 5'h17;
  localparam logic [4:0]  GLR_IDX_FRAME_PERIOD  = 5'h18;
  localparam logic [4:0]  GLR_IDX_FDIV_CTRL     = 5'h19;
  localparam logic [4:0]  GLR_IDX_PULSE_CTRL    = 5'h1a;
  localparam logic [4:0]  GLR_IDX_H_DELAY       = 5'h1b;
  localparam logic [4:0]  GLR_IDX_STATUS        = 5'h1c;
  localparam int          GLR_BIT_GL_HOST       = 0;
  localparam int          GLR_BIT_GL_FROM_HOST  = 5;
  localparam int          GLR_BIT_FRAME_MODE    = 0;
  localparam int          GLR_BIT_FRAME_STROBE  = 1;
  localparam int          GLR_BIT_PULSE_STROBE  = 0;
  localparam int          GLR_BIT_TFID_EN       = 2;
  localparam int          GLR_BIT_AFS_EN        = 3;
  localparam logic [15:0] GLR_RST_ZERO          = 16'h0000;
  localparam logic [15:0] GLR_RST_LINE_PERIOD   = 16'h0000;
  localparam logic [15:0] GLR_RST_FRAME_PERIOD  = 16'h0000;
  localparam logic [15:0] GLR_MASK_GENLOCK_CTRL = 16'h0021;
  localparam logic [15:0] GLR_MASK_FDIV_CTRL    = 16'h0003;
  localparam logic [15:0] GLR_MASK_PULSE_CTRL   = 16'h000d;
  localparam logic [15:0] GLR_ONE               = 16'h0001;
  typedef enum logic [1:0] {
    GLR_ARM_IDLE   = 2'b00,
    GLR_ARM_WAIT   = 2'b01,
    GLR_ARM_FIRE   = 2'b10
  } glr_arm_type;
endpackage : glr_pkg
`default_nettype wire

//--- src/glr_genlock_reset.sv
/*
  Genlock counter reset and horizontal offset control: host registers,
  reference-driven and period-driven counter resets, host-armed frame and
  pulse resets, and the once-per-field horizontal delay sample.
  Assumes reference syncs arrive from pins asynchronous to clk, and that
  output frame/field boundaries come as one-cycle pulses on clk.
*/
// The address-and-strobe port was left to the implementer.
// Overview of operation
// RULE1: Genlocked reference line sync resets line counter; code resets it once per reference frame sync instead
// RULE2: Nonzero line period resets every N lines
// RULE3: Genlocked reference frame sync resets frame counter
// RULE4: Nonzero frame period resets every N input frames
// RULE5: Host updates frame period through divider control
// RULE6: Frame mode selects host strobe over reference
// RULE7: Frame strobe pulse resets in following frame
// RULE8: Host writes zeros to reserved bits
// RULE9: Audio enable lets strobe reset audio pulse
// RULE10: Ten-field enable lets strobe reset ID pulse
// RULE11: Missing ten-field input tied low, host resets
// RULE12: Pulse strobe resets enabled pulses next frame
// RULE13: Horizontal output delayed by programmed pixel count
// RULE14: Host keeps delay within one line
// RULE15: Advance programmed as maximum minus advance
// RULE16: Delay sampled once per field only
// RULE17: Strobe rising edge arms exactly one reset
// RULE18: Host genlock select picks host bit or pin
`timescale 1ns/1ps
`default_nettype none
module glr_genlock_reset
  import glr_pkg::*;
#(
  parameter bit HAS_AUDIO = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [GLR_AW-1:0] reg_addr,
  input  wire logic [GLR_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [GLR_DW-1:0] reg_rdata,
  input  wire logic              genlock_pin,
  input  wire logic              ref_line_sync,
  input  wire logic              ref_frame_sync,
  input  wire logic              out_line_start,
  input  wire logic              out_frame_start,
  input  wire logic              out_field_start,
  output var  logic              line_counter_reset,
  output var  logic              frame_counter_reset,
  output var  logic              ten_field_id_pulse_reset,
  output var  logic              audio_frame_sync_pulse_reset,
  output var  logic [GLR_DW-1:0] h_delay_active
);

  // Register file
  logic [GLR_DW-1:0] genlock_ctrl_q;
  logic [GLR_DW-1:0] line_reset_period_q;
  logic [GLR_DW-1:0] frame_reset_period_q;
  logic [GLR_DW-1:0] frame_divider_reset_ctrl_q;
  logic [GLR_DW-1:0] pulse_reset_ctrl_q;
  logic [GLR_DW-1:0] horizontal_output_delay_q;
  logic [GLR_DW-1:0] h_delay_active_q;
  logic [GLR_DW-1:0] reg_rdata_q;

  wire wr_gl    = reg_wr && (reg_addr == GLR_IDX_GENLOCK_CTRL);
  wire wr_line  = reg_wr && (reg_addr == GLR_IDX_LINE_PERIOD);
  wire wr_frame = reg_wr && (reg_addr == GLR_IDX_FRAME_PERIOD);
  wire wr_fdiv  = reg_wr && (reg_addr == GLR_IDX_FDIV_CTRL);
  wire wr_pulse = reg_wr && (reg_addr == GLR_IDX_PULSE_CTRL);
  wire wr_hdel  = reg_wr && (reg_addr == GLR_IDX_H_DELAY);

  // Audio enable stuck low in the variant without audio
  wire [GLR_DW-1:0] pulse_mask = HAS_AUDIO ? GLR_MASK_PULSE_CTRL
                                           : (GLR_MASK_PULSE_CTRL & ~(GLR_ONE << GLR_BIT_AFS_EN));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      genlock_ctrl_q             <= GLR_RST_ZERO;
      line_reset_period_q        <= GLR_RST_LINE_PERIOD;
      frame_reset_period_q       <= GLR_RST_FRAME_PERIOD;
      frame_divider_reset_ctrl_q <= GLR_RST_ZERO;
      pulse_reset_ctrl_q         <= GLR_RST_ZERO;
      horizontal_output_delay_q  <= GLR_RST_ZERO;
    end else begin
      if (wr_gl)    genlock_ctrl_q             <= reg_wdata & GLR_MASK_GENLOCK_CTRL;
      if (wr_line)  line_reset_period_q        <= reg_wdata;
      if (wr_frame) frame_reset_period_q       <= reg_wdata;
      if (wr_fdiv)  frame_divider_reset_ctrl_q <= reg_wdata & GLR_MASK_FDIV_CTRL;  // [RULE5] [RULE8]
      if (wr_pulse) pulse_reset_ctrl_q         <= reg_wdata & pulse_mask;          // [RULE9] [RULE8]
      if (wr_hdel)  horizontal_output_delay_q  <= reg_wdata;
    end
  end

  // Genlock source select
  logic [2:0] gl_pin_s;
  logic       gl_pin_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gl_pin_s <= 3'h0;
      gl_pin_q <= 1'b0;
    end else begin
      gl_pin_s <= {gl_pin_s[1:0], genlock_pin};
      if (gl_pin_s[1] == gl_pin_s[2]) gl_pin_q <= gl_pin_s[2];
    end
  end
  wire genlocked = genlock_ctrl_q[GLR_BIT_GL_FROM_HOST] ? genlock_ctrl_q[GLR_BIT_GL_HOST]
                                                        : gl_pin_q;  // [RULE18]

  // Reference sync inputs: three stages, edge counts once stages 2 and 3 agree
  // A lone metastable sample cannot make a false edge
  logic [2:0] rl_s;
  logic [2:0] rf_s;
  logic       rl_q;
  logic       rf_q;
  logic       rl_prev_q;
  logic       rf_prev_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rl_s      <= 3'h0;
      rf_s      <= 3'h0;
      rl_q      <= 1'b0;
      rf_q      <= 1'b0;
      rl_prev_q <= 1'b0;
      rf_prev_q <= 1'b0;
    end else begin
      rl_s      <= {rl_s[1:0], ref_line_sync};
      rf_s      <= {rf_s[1:0], ref_frame_sync};
      if (rl_s[1] == rl_s[2]) rl_q <= rl_s[2];
      if (rf_s[1] == rf_s[2]) rf_q <= rf_s[2];
      rl_prev_q <= rl_q;
      rf_prev_q <= rf_q;
    end
  end
  wire ref_line_edge  = rl_q && !rl_prev_q;
  wire ref_frame_edge = rf_q && !rf_prev_q;

  // Line-period override counter
  // Cleared while unlocked so a relock starts a whole period
  logic [GLR_DW-1:0] line_cnt_q;
  wire line_override = (line_reset_period_q != GLR_RST_ZERO);
  wire line_cnt_wrap = (line_cnt_q >= line_reset_period_q - GLR_ONE);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_cnt_q <= GLR_RST_ZERO;
    end else if (!genlocked || !line_override) begin
      line_cnt_q <= GLR_RST_ZERO;
    end else if (ref_line_edge) begin
      line_cnt_q <= line_cnt_wrap ? GLR_RST_ZERO : line_cnt_q + GLR_ONE;  // [RULE2]
    end
  end
  // Override: every N reference lines; otherwise once per reference frame
  wire line_reset_d = genlocked && (line_override ? (ref_line_edge && line_cnt_wrap)  // [RULE2]
                                                  : ref_frame_edge);                  // [RULE1]

  // Frame-period override counter
  logic [GLR_DW-1:0] frame_cnt_q;
  wire frame_override = (frame_reset_period_q != GLR_RST_ZERO);
  wire frame_cnt_wrap = (frame_cnt_q >= frame_reset_period_q - GLR_ONE);
  wire host_frame_mode = frame_divider_reset_ctrl_q[GLR_BIT_FRAME_MODE];
  logic host_frame_fire;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_cnt_q <= GLR_RST_ZERO;
    end else if (!genlocked || !frame_override || host_frame_fire) begin
      frame_cnt_q <= GLR_RST_ZERO;  // Host strobe re-phases the divider
    end else if (ref_frame_edge) begin
      frame_cnt_q <= frame_cnt_wrap ? GLR_RST_ZERO : frame_cnt_q + GLR_ONE;  // [RULE4]
    end
  end
  wire ref_frame_reset = genlocked && ref_frame_edge &&
                         (frame_override ? frame_cnt_wrap : 1'b1);  // [RULE3] [RULE4]

  // Host strobes: rising edge of the register bit, one arm per edge
  // Bits do not self-clear: a second reset needs a write of zero first
  logic fstb_prev_q;
  logic pstb_prev_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fstb_prev_q <= 1'b0;
      pstb_prev_q <= 1'b0;
    end else begin
      fstb_prev_q <= frame_divider_reset_ctrl_q[GLR_BIT_FRAME_STROBE];
      pstb_prev_q <= pulse_reset_ctrl_q[GLR_BIT_PULSE_STROBE];
    end
  end
  wire fstb_rise = frame_divider_reset_ctrl_q[GLR_BIT_FRAME_STROBE] && !fstb_prev_q;  // [RULE17]
  wire pstb_rise = pulse_reset_ctrl_q[GLR_BIT_PULSE_STROBE] && !pstb_prev_q;          // [RULE17]

  // Arm on strobe, wait for the next output frame start, fire in that frame
  glr_arm_type farm_q;
  glr_arm_type parm_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      farm_q <= GLR_ARM_IDLE;
    end else begin
      case (farm_q)
        GLR_ARM_IDLE: if (fstb_rise && host_frame_mode) farm_q <= GLR_ARM_WAIT;  // [RULE6]
        GLR_ARM_WAIT: if (out_frame_start) farm_q <= GLR_ARM_FIRE;              // [RULE7]
        default:      farm_q <= GLR_ARM_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      parm_q <= GLR_ARM_IDLE;
    end else begin
      case (parm_q)
        GLR_ARM_IDLE: if (pstb_rise) parm_q <= GLR_ARM_WAIT;      // [RULE12]
        GLR_ARM_WAIT: if (out_frame_start) parm_q <= GLR_ARM_FIRE;  // [RULE12]
        default:      parm_q <= GLR_ARM_IDLE;
      endcase
    end
  end
  assign host_frame_fire = (farm_q == GLR_ARM_FIRE);
  wire pulse_fire = (parm_q == GLR_ARM_FIRE);

  // Host mode replaces the reference as the source of the frame reset
  wire frame_reset_d = host_frame_mode ? host_frame_fire : ref_frame_reset;  // [RULE6]
  // Independent of reference resets; enables sampled at fire time
  wire tfid_reset_d = pulse_fire && pulse_reset_ctrl_q[GLR_BIT_TFID_EN];  // [RULE10] [RULE11]
  wire audio_frame_pulse_reset_enable_d  = pulse_fire && pulse_reset_ctrl_q[GLR_BIT_AFS_EN];   // [RULE9]

  // Horizontal delay taken up at field start only, so a line never tears
  wire [GLR_DW-1:0] h_delay_d = out_field_start ? horizontal_output_delay_q : h_delay_active_q;  // [RULE16]

  // Readback
  wire [GLR_DW-1:0] status_word = {12'h000, genlocked, host_frame_fire, farm_q != GLR_ARM_IDLE,
                                   parm_q != GLR_ARM_IDLE};
  logic [GLR_DW-1:0] rdata_d;
  always_comb begin
    case (reg_addr)
      GLR_IDX_GENLOCK_CTRL: rdata_d = genlock_ctrl_q;
      GLR_IDX_LINE_PERIOD:  rdata_d = line_reset_period_q;
      GLR_IDX_FRAME_PERIOD: rdata_d = frame_reset_period_q;
      GLR_IDX_FDIV_CTRL:    rdata_d = frame_divider_reset_ctrl_q;
      GLR_IDX_PULSE_CTRL:   rdata_d = pulse_reset_ctrl_q;
      GLR_IDX_H_DELAY:      rdata_d = horizontal_output_delay_q;
      GLR_IDX_STATUS:       rdata_d = status_word;
      default:              rdata_d = GLR_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q                  <= GLR_RST_ZERO;
      line_counter_reset           <= 1'b0;
      frame_counter_reset          <= 1'b0;
      ten_field_id_pulse_reset     <= 1'b0;
      audio_frame_sync_pulse_reset <= 1'b0;
      h_delay_active_q             <= GLR_RST_ZERO;
    end else begin
      reg_rdata_q                  <= reg_rd ? rdata_d : GLR_RST_ZERO;
      line_counter_reset           <= line_reset_d;
      frame_counter_reset          <= frame_reset_d;
      ten_field_id_pulse_reset     <= tfid_reset_d;
      audio_frame_sync_pulse_reset <= audio_frame_pulse_reset_enable_d;
      h_delay_active_q             <= h_delay_d;  // [RULE13]
    end
  end
  assign reg_rdata      = reg_rdata_q;
  assign h_delay_active = h_delay_active_q;  // [RULE13] [RULE14] [RULE15]

  // Assertions
  sequence s_pstrobe_armed;
    pstb_rise ##1 (parm_q == GLR_ARM_WAIT);
  endsequence
  sequence s_frame_then_fire;
    out_frame_start ##1 (parm_q == GLR_ARM_FIRE);
  endsequence

  a_line_period_reset: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE2]
    (genlocked && line_override && ref_line_edge && line_cnt_wrap) |=> line_counter_reset)
    else $error("line period reset missing");
  a_line_ref_reset: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE1]
    (genlocked && !line_override && ref_frame_edge) |=> line_counter_reset)
    else $error("reference line reset missing");
  a_no_reset_unlocked: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE3]
    (!genlocked && !host_frame_mode) |=> !frame_counter_reset)
    else $error("frame reset while not genlocked");
  a_frame_period_reset: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE4]
    (!host_frame_mode && ref_frame_reset) |=> frame_counter_reset)
    else $error("frame period reset missing");
  a_host_mode_blocks: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE6]
    (host_frame_mode && !host_frame_fire) |=> !frame_counter_reset)
    else $error("reference reset leaked in host mode");
  a_frame_strobe_fire: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE7]
    (farm_q == GLR_ARM_WAIT && out_frame_start) |=> host_frame_fire ##1
      (frame_counter_reset == $past(host_frame_mode)))
    else $error("host frame reset not in next frame");
  a_pulse_arm_fire: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE12]
    s_pstrobe_armed |-> (parm_q == GLR_ARM_WAIT) until out_frame_start)
    else $error("pulse arm lost before frame");
  a_tfid_reset: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE10]
    s_frame_then_fire |=> (ten_field_id_pulse_reset == $past(pulse_reset_ctrl_q[GLR_BIT_TFID_EN])))
    else $error("ten field id reset wrong");
  a_audio_frame_pulse_reset_enable: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE9]
    audio_frame_sync_pulse_reset |-> $past(pulse_fire) && $past(pulse_reset_ctrl_q[GLR_BIT_AFS_EN]))
    else $error("audio pulse reset without cause");
  a_hdelay_hold: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE16]
    !out_field_start |=> $stable(h_delay_active_q))
    else $error("delay changed outside field start");
  a_hdelay_take: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE13]
    out_field_start |=> h_delay_active_q == $past(horizontal_output_delay_q))
    else $error("delay not taken at field start");
  a_one_arm: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE17]
    (parm_q == GLR_ARM_FIRE) |=> (parm_q == GLR_ARM_IDLE))
    else $error("pulse reset fired twice");
  a_genlock_sel: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE18]
    genlock_ctrl_q[GLR_BIT_GL_FROM_HOST] |-> genlocked == genlock_ctrl_q[GLR_BIT_GL_HOST])
    else $error("genlock select wrong");

  // Quiet cycles matter as much as the pulses themselves
  a_line_unlocked: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE1]
    !genlocked |=> !line_counter_reset)
    else $error("line reset while not genlocked");
  a_line_period_quiet: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE2]
    (genlocked && line_override && !(ref_line_edge && line_cnt_wrap)) |=> !line_counter_reset)
    else $error("line reset between period ends");
  a_fstrobe_mode: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE6]
    (farm_q == GLR_ARM_IDLE && !host_frame_mode) |=> (farm_q == GLR_ARM_IDLE))
    else $error("frame strobe armed outside host mode");
  a_frame_arm_hold: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE7]
    (farm_q == GLR_ARM_WAIT && !out_frame_start) |=> (farm_q == GLR_ARM_WAIT))
    else $error("frame arm lost before frame start");
  a_pulse_idle: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE12]
    (parm_q == GLR_ARM_IDLE && !pstb_rise) |=> (parm_q == GLR_ARM_IDLE))
    else $error("pulse reset armed without strobe");
  a_pulse_single: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE17]
    (ten_field_id_pulse_reset || audio_frame_sync_pulse_reset) |=>
      !(ten_field_id_pulse_reset || audio_frame_sync_pulse_reset))
    else $error("pulse reset longer than one cycle");

  sequence s_frame_fire_step;
    (farm_q == GLR_ARM_WAIT && out_frame_start) ##1 host_frame_fire;
  endsequence
  a_frame_fire_once: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE17]
    s_frame_fire_step |=> !host_frame_fire)
    else $error("host frame reset fired twice");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE8]
    ((frame_divider_reset_ctrl_q & ~GLR_MASK_FDIV_CTRL) == GLR_RST_ZERO) &&
    ((pulse_reset_ctrl_q & ~GLR_MASK_PULSE_CTRL) == GLR_RST_ZERO))
    else $error("reserved control bits stored");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_rd |=> (reg_rdata_q == GLR_RST_ZERO))
    else $error("read data outside its cycle");
  a_rdata_delay: assert property (@(posedge clk) disable iff (!arst_n)  // [RULE13]
    (reg_rd && reg_addr == GLR_IDX_H_DELAY) |=> (reg_rdata_q == $past(horizontal_output_delay_q)))
    else $error("delay readback wrong");

endmodule : glr_genlock_reset
`default_nettype wire

//--- testbench/glr_ref_model.sv
/*
  Far-side timing source: reference line and frame syncs plus the
  output line, frame and field start pulses.
  Assumes the bench clock; one line is LINE_CYC cycles, four lines a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module glr_ref_model #(
  parameter int LINE_CYC    = 20,
  parameter int FRAME_LINES = 4
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output var  logic ref_line_sync,
  output var  logic ref_frame_sync,
  output var  logic out_line_start,
  output var  logic out_frame_start,
  output var  logic out_field_start
);
  localparam int FRAME_CYC = LINE_CYC * FRAME_LINES;
  int pos_q;
  // Syncs are wide levels so the pin synchronisers cannot miss them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q           <= 0;
      ref_line_sync   <= 1'b0;
      ref_frame_sync  <= 1'b0;
      out_line_start  <= 1'b0;
      out_frame_start <= 1'b0;
      out_field_start <= 1'b0;
    end else begin
      pos_q           <= (pos_q == FRAME_CYC - 1) ? 0 : pos_q + 1;
      ref_line_sync   <= (pos_q % LINE_CYC) < 4;
      ref_frame_sync  <= pos_q < 8;
      out_line_start  <= (pos_q % LINE_CYC) == 10;
      out_frame_start <= pos_q == FRAME_CYC / 2;
      out_field_start <= (pos_q == 0) || (pos_q == FRAME_CYC / 2);
    end
  end
endmodule : glr_ref_model
`default_nettype wire

//--- testbench/glr_genlock_reset_tb.sv
/*
  Self-checking bench for the genlock reset block.
  Assumes the reference model above: 20-cycle lines, 80-cycle frames.
*/
`timescale 1ns/1ps
`default_nettype none
module glr_genlock_reset_tb;
  import glr_pkg::*;
  logic              clk;
  logic              arst_n;
  logic [GLR_AW-1:0] reg_addr;
  logic [GLR_DW-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [GLR_DW-1:0] reg_rdata;
  logic              genlock_pin;
  logic              rl, rf, ol, of, od;
  logic              lcr, fcr, tfr, afr;
  logic [GLR_DW-1:0] h_delay_active;
  int                bad_count, num_checks, n_l, n_f, n_t, n_a;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  glr_ref_model i_ref (.clk(clk), .arst_n(arst_n), .ref_line_sync(rl), .ref_frame_sync(rf),
    .out_line_start(ol), .out_frame_start(of), .out_field_start(od));
  glr_genlock_reset i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .genlock_pin(genlock_pin),
    .ref_line_sync(rl), .ref_frame_sync(rf), .out_line_start(ol), .out_frame_start(of),
    .out_field_start(od), .line_counter_reset(lcr), .frame_counter_reset(fcr),
    .ten_field_id_pulse_reset(tfr), .audio_frame_sync_pulse_reset(afr),
    .h_delay_active(h_delay_active));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp, "read data");
    @(posedge clk);
    #1 check(reg_rdata, 16'h0000, "read data after its cycle");
  endtask : rd

  // Counts the reset pulses seen over a span of cycles
  task automatic count(input int cyc);
    n_l = 0;
    n_f = 0;
    n_t = 0;
    n_a = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      n_l += (lcr === 1'b1);
      n_f += (fcr === 1'b1);
      n_t += (tfr === 1'b1);
      n_a += (afr === 1'b1);
    end
  endtask : count

  // Waits for an output frame (or field) start; frame resets are tallied meanwhile
  task automatic wait_start(input bit field);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      n_f += (fcr === 1'b1);
      i++;
    end while ((field ? od : of) !== 1'b1 && i < 200);
    if (i >= 200) check(16'h0000, 16'h0001, "no output start");
  endtask : wait_start

  task automatic chk_lf(input int l, input int f);
    check(16'(n_l), 16'(l), "line reset count");
    check(16'(n_f), 16'(f), "frame reset count");
  endtask : chk_lf

  task automatic t_regs;
    for (int a = 5'h17; a <= 5'h1b; a++) rd(5'(a), 16'h0000);
    rd(5'h00, 16'h0000);
    wr(GLR_IDX_GENLOCK_CTRL, 16'hffff);
    rd(GLR_IDX_GENLOCK_CTRL, 16'h0021);
    wr(GLR_IDX_GENLOCK_CTRL, 16'h0000);
    wr(GLR_IDX_H_DELAY, 16'hbeef);
    rd(GLR_IDX_H_DELAY, 16'hbeef);
    wr(GLR_IDX_FDIV_CTRL, 16'hffff);
    rd(GLR_IDX_FDIV_CTRL, 16'h0003);
    wr(GLR_IDX_PULSE_CTRL, 16'hffff);
    rd(GLR_IDX_PULSE_CTRL, 16'h000d);
    wr(GLR_IDX_FDIV_CTRL, 16'h0000);
    wr(GLR_IDX_PULSE_CTRL, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ref;
    genlock_pin <= 1'b1;
    count(240);
    count(320);
    chk_lf(4, 4);
    wr(GLR_IDX_LINE_PERIOD, 16'h0003);
    wr(GLR_IDX_FRAME_PERIOD, 16'h0003);
    wr(GLR_IDX_FDIV_CTRL, 16'h0000);
    count(240);
    count(480);
    chk_lf(8, 2);
    wr(GLR_IDX_LINE_PERIOD, 16'h0000);
    wr(GLR_IDX_FRAME_PERIOD, 16'h0000);
    genlock_pin <= 1'b0;
    count(240);
    count(160);
    chk_lf(0, 0);
    wr(GLR_IDX_GENLOCK_CTRL, 16'h0021);
    count(160);
    count(160);
    chk_lf(2, 2);
    wr(GLR_IDX_GENLOCK_CTRL, 16'h0020);
    genlock_pin <= 1'b1;
    count(160);
    count(160);
    chk_lf(0, 0);
    wr(GLR_IDX_GENLOCK_CTRL, 16'h0021);
    $display("test ref done");
  endtask : t_ref

  task automatic t_host;
    wr(GLR_IDX_FDIV_CTRL, 16'h0001);
    count(160);
    count(160);
    chk_lf(2, 0);
    wait_start(1'b0);
    wr(GLR_IDX_FDIV_CTRL, 16'h0003);
    wr(GLR_IDX_FDIV_CTRL, 16'h0001);
    rd(GLR_IDX_STATUS, 16'h000a);
    n_f = 0;
    wait_start(1'b0);
    check(16'(n_f), 16'h0000, "early frame reset");
    count(80);
    check(16'(n_f), 16'h0001, "host frame reset");
    count(160);
    check(16'(n_f), 16'h0000, "extra frame reset");
    $display("test host done");
  endtask : t_host

  task automatic t_pulse;
    logic [15:0] en;
    for (int k = 1; k < 4; k++) begin
      en = 16'(k << 2);
      wait_start(1'b0);
      wr(GLR_IDX_PULSE_CTRL, en | 16'h0001);
      wr(GLR_IDX_PULSE_CTRL, en);
      wait_start(1'b0);
      count(160);
      check(16'(n_t), 16'(en[2]), "ten field reset count");
      check(16'(n_a), 16'(en[3]), "audio sync reset count");
      check(16'(n_f), 16'h0000, "frame reset from pulse strobe");
    end
    wr(GLR_IDX_PULSE_CTRL, 16'h0000);
    wr(GLR_IDX_FDIV_CTRL, 16'h0000);
    $display("test pulse done");
  endtask : t_pulse

  task automatic t_hdelay;
    wait_start(1'b1);
    wr(GLR_IDX_H_DELAY, 16'd13);
    #1 check(h_delay_active, 16'hbeef, "delay before field");
    wait_start(1'b1);
    repeat (2) @(posedge clk);
    #1 check(h_delay_active, 16'd13, "delay after field");
    $display("test hdelay done");
  endtask : t_hdelay

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    bad_count   = 0;
    num_checks  = 0;
    arst_n      = 1'b0;
    reg_addr    = '0;
    reg_wdata   = '0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    genlock_pin = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_ref();
    t_host();
    t_pulse();
    t_hdelay();
    give_verdict();
  end

  // Tests need about 4200 cycles; this allows several times that
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule : glr_genlock_reset_tb
`default_nettype wire
